/* rtl/fbd_timing_params.svh */
// Register offsets, field ranges, reset values and timing counts for the
// memory timing control block. Included by the block's package users.
// Assumes a byte address bus, 32-bit registers, a 10 MHz core clock.
`ifndef FBD_TIMING_PARAMS_SVH
`define FBD_TIMING_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_DRAM_TIMING_A 8'h48
`define OFS_TURNAROUND_B 8'h4C
`define OFS_QUEUE_STATUS 8'h50
`define OFS_LANE_DEFER 8'h5C
`define OFS_ERR_PERIOD_LIMIT 8'h60
`define OFS_ERR_PERIOD 8'h64

// ----------------------------------------
// Field ranges
// ----------------------------------------
`define F_ADDITIVE_LAT 30:28
`define F_ACT_WRC 27:22
`define F_SAME_BANK 21:16
`define F_REF_ACT 15:8
`define F_CROSS_BANK 7:4
`define F_REF_CODE 3:0
`define F_WR_RD_XR 18:16
`define F_RD_WR 15:12
`define F_WR_RD_SR 11:8
`define F_RD_RD_XR 7:4
`define F_WR_WR 3:0
`define F_IDLE_IGN 5
`define F_EDGE_DIS 4
`define F_DEFER 3:0
`define F_IORD 23:17
`define F_DEFRD 16:10
`define F_WQ 6:1
`define F_WPOST 0

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define DEFER_RESET 4'h6
`define REF_MAX_PEND 4'h9
`define ERR_PRESCALE_CYCLES 524288
`define RI_1 11'h041
`define RI_2 11'h051
`define RI_3 11'h061
`define RI_4 11'h07C
`define RI_5 11'h09A
`define RI_6 11'h082
`define RI_7 11'h0A2
`define RI_8 11'h0B9
`define RI_9 11'h0C3
`define RI_A 11'h0FA
`define RI_B 11'h1F4
`define RI_C 11'h3E8
`define RI_D 11'h5DC
`define RI_E 11'h7D0

`endif

/* rtl/fbd_timing_pkg.sv */
// Types shared by the memory timing control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package fbd_timing_pkg;
  typedef enum logic [1:0] {
    CMD_ACT = 2'h0,
    CMD_RD = 2'h1,
    CMD_WR = 2'h2,
    CMD_REF = 2'h3
  } cmd_kind_t;
endpackage
`default_nettype wire

/* rtl/gap_age.sv */
// Saturating age counter: cycles since the last clearing event.
// Assumes a synchronous active-high reset on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module gap_age #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clear,
  output logic [W-1:0] age_r
);
  // Clear loads one so age equals command spacing on the next decision
  logic [W-1:0] age_nxt;

  assign age_nxt = clear ? W'(1) : ((&age_r) ? age_r : age_r + W'(1));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      age_r <= '1;
    end else begin
      age_r <= age_nxt;
    end
  end
endmodule
`default_nettype wire

/* rtl/fbd_memory_timing_control.sv */
// Memory controller lane control, queue status, DRAM command spacing,
// refresh scheduling, early defer reply and error period counter.
// Assumes inputs synchronous to ref_clk and a host that holds a request
// until it sees req_accept_r.
`timescale 1ns/1ns
`default_nettype none
`include "fbd_timing_params.svh"
module fbd_memory_timing_control
  import fbd_timing_pkg::*;
#(
  parameter int LANES = 14,
  parameter int MODULES = 2,
  parameter int RANKS = 2,
  parameter int BANKS = 4,
  parameter int RET_LAT = 24,
  parameter int ERR_PRESCALE = `ERR_PRESCALE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata_r,
  input wire logic [LANES-1:0] electrical_idle,
  input wire logic soft_core_reset,
  input wire logic cal_active,
  output logic [LANES-1:0] cal_detect_en_r,
  output logic [LANES-1:0] edge_off_r,
  output logic rx_train_en_r,
  input wire logic [6:0] inorder_depth_in,
  input wire logic [6:0] deferred_depth_in,
  input wire logic [5:0] write_depth_in,
  input wire logic write_pending_in,
  input wire logic req_valid,
  input wire cmd_kind_t req_kind,
  input wire logic req_close,
  input wire logic [$clog2(MODULES)-1:0] req_module,
  input wire logic [$clog2(RANKS)-1:0] req_rank,
  input wire logic [$clog2(BANKS)-1:0] req_bank,
  output logic req_accept_r,
  output logic issue_valid_r,
  output cmd_kind_t issue_kind_r,
  output logic [$clog2(MODULES*RANKS)-1:0] issue_rank_r,
  output logic [$clog2(BANKS)-1:0] issue_bank_r,
  output logic early_defer_r,
  output logic data_arrive_r,
  output logic err_decrement_r
);
  localparam int RK = MODULES * RANKS;
  localparam int NB = RK * BANKS;
  localparam int RW = $clog2(RK);
  localparam int BW = $clog2(BANKS);
  localparam int MW = $clog2(MODULES);
  localparam int PW = $clog2(ERR_PRESCALE);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Concatenated rank and bank indices need powers of two
  if ((1 << BW) != BANKS || (1 << $clog2(RANKS)) != RANKS || (1 << MW) != MODULES ||
      BANKS < 2 || RANKS < 2 || MODULES < 2) begin : g_bad_geom
    $error("Geometry must be powers of two, at least two each");
  end
  if (RET_LAT <= 16 || ERR_PRESCALE < 2 || LANES < 1) begin : g_bad_param
    $error("Return latency must exceed the largest defer lead");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] dram_timing_a_r;
  logic [31:0] dram_turnaround_timing_b_r;
  logic idle_ignore_train_enable_r;
  logic edge_off_disable_r;
  logic [3:0] defer_reply_launch_delay_r;
  logic defer_locked_r;
  logic [31:0] error_period_threshold_r;
  logic [6:0] inorder_read_depth_r;
  logic [6:0] deferred_read_depth_r;
  logic [5:0] write_queue_occupancy_r;
  logic writes_posted_r;

  wire logic wr_timing_a = reg_write && (reg_addr == `OFS_DRAM_TIMING_A);
  wire logic wr_timing_b = reg_write && (reg_addr == `OFS_TURNAROUND_B);
  wire logic wr_lane_defer = reg_write && (reg_addr == `OFS_LANE_DEFER);
  wire logic wr_err_period_limit = reg_write && (reg_addr == `OFS_ERR_PERIOD_LIMIT);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dram_timing_a_r <= 32'h0;
      dram_turnaround_timing_b_r <= 32'h0;
      error_period_threshold_r <= 32'h0;
      idle_ignore_train_enable_r <= 1'b0;
      edge_off_disable_r <= 1'b0;
    end else begin
      if (wr_timing_a) begin
        dram_timing_a_r <= {1'b0, reg_wdata[30:0]};
      end
      if (wr_timing_b) begin
        dram_turnaround_timing_b_r <= {13'h0, reg_wdata[18:0]};
      end
      if (wr_err_period_limit) begin
        error_period_threshold_r <= reg_wdata;
      end
      if (wr_lane_defer) begin
        idle_ignore_train_enable_r <= reg_wdata[`F_IDLE_IGN];
        edge_off_disable_r <= reg_wdata[`F_EDGE_DIS];
      end
    end
  end

  // Write-once: first write after reset sticks, later ones are dropped
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      defer_reply_launch_delay_r <= `DEFER_RESET;
      defer_locked_r <= 1'b0;
    end else if (wr_lane_defer && !defer_locked_r) begin
      defer_reply_launch_delay_r <= reg_wdata[`F_DEFER];
      defer_locked_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Queue status capture
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      inorder_read_depth_r <= 7'h0;
      deferred_read_depth_r <= 7'h0;
      write_queue_occupancy_r <= 6'h0;
      writes_posted_r <= 1'b0;
    end else begin
      inorder_read_depth_r <= inorder_depth_in;
      deferred_read_depth_r <= deferred_depth_in;
      write_queue_occupancy_r <= write_depth_in;
      writes_posted_r <= (|write_depth_in) || write_pending_in;
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  logic [31:0] err_period_cnt_r;
  wire logic [31:0] status_word = {8'h0, inorder_read_depth_r, deferred_read_depth_r,
                                   3'h0, write_queue_occupancy_r, writes_posted_r};
  wire logic [31:0] lane_word = {26'h0, idle_ignore_train_enable_r, edge_off_disable_r,
                                 defer_reply_launch_delay_r};
  wire logic [31:0] rd_mux =
    (reg_addr == `OFS_DRAM_TIMING_A) ? dram_timing_a_r :
    (reg_addr == `OFS_TURNAROUND_B) ? dram_turnaround_timing_b_r :
    (reg_addr == `OFS_QUEUE_STATUS) ? status_word :
    (reg_addr == `OFS_LANE_DEFER) ? lane_word :
    (reg_addr == `OFS_ERR_PERIOD_LIMIT) ? error_period_threshold_r :
    (reg_addr == `OFS_ERR_PERIOD) ? err_period_cnt_r : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata_r <= 32'h0;
    end else begin
      reg_rdata_r <= reg_read ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------
  // Northbound lane control
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cal_detect_en_r <= '0;
      edge_off_r <= '0;
      rx_train_en_r <= 1'b0;
    end else begin
      // Idle lanes are masked unless the option ignores idle sensing
      cal_detect_en_r <= {LANES{idle_ignore_train_enable_r}} | ~electrical_idle;
      rx_train_en_r <= cal_active && idle_ignore_train_enable_r;
      // Soft core reset still forces edge-off even when idle gating is off
      edge_off_r <= {LANES{soft_core_reset}} |
                    (electrical_idle & {LANES{!edge_off_disable_r}});
    end
  end

  // ----------------------------------------
  // Spacing fields, widened to the age width
  // ----------------------------------------
  wire logic [7:0] g_wrc = 8'(dram_timing_a_r[`F_ACT_WRC]);
  wire logic [7:0] g_same = 8'(dram_timing_a_r[`F_SAME_BANK]);
  wire logic [7:0] g_ref = dram_timing_a_r[`F_REF_ACT];
  wire logic [7:0] g_cross = 8'(dram_timing_a_r[`F_CROSS_BANK]);
  wire logic [7:0] g_wr_rd_xr = 8'(dram_turnaround_timing_b_r[`F_WR_RD_XR]);
  wire logic [7:0] g_rd_wr = 8'(dram_turnaround_timing_b_r[`F_RD_WR]);
  wire logic [7:0] g_wr_rd_sr = 8'(dram_turnaround_timing_b_r[`F_WR_RD_SR]);
  wire logic [7:0] g_rd_rd_xr = 8'(dram_turnaround_timing_b_r[`F_RD_RD_XR]);
  wire logic [7:0] g_wr_wr = 8'(dram_turnaround_timing_b_r[`F_WR_WR]);

  // ----------------------------------------
  // Issue selection
  // ----------------------------------------
  logic go_ref;
  logic go_host;
  logic [RW-1:0] ref_rank;
  logic [RK-1:0] ref_ok;
  logic [RK-1:0] rd_blk;
  logic [RK-1:0] wr_blk;
  logic [RK-1:0] act_blk;
  logic [NB-1:0] bank_ok;
  logic ref_tick;

  wire logic [RW-1:0] req_gr = {req_module, req_rank};
  wire logic [RW+BW-1:0] req_bi = {req_gr, req_bank};
  wire logic act_ok = !(|act_blk) && bank_ok[req_bi];
  wire logic host_ok = req_valid && !issue_valid_r &&
                       (((req_kind == CMD_ACT) && act_ok) ||
                        ((req_kind == CMD_RD) && !(|rd_blk)) ||
                        ((req_kind == CMD_WR) && !(|wr_blk)));

  // Lowest pending rank that may refresh now; refresh beats host traffic
  always_comb begin
    ref_rank = '0;
    for (int r = RK - 1; r >= 0; r--) begin
      if (ref_ok[r]) begin
        ref_rank = RW'(r);
      end
    end
  end

  assign go_ref = !issue_valid_r && (|ref_ok);
  assign go_host = host_ok && !go_ref;
  wire logic iss = go_ref || go_host;
  wire cmd_kind_t iss_kind = go_ref ? CMD_REF : req_kind;
  wire logic [RW-1:0] iss_rank = go_ref ? ref_rank : req_gr;
  wire logic [RW+BW-1:0] iss_bi = {iss_rank, req_bank};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      issue_valid_r <= 1'b0;
      issue_kind_r <= CMD_ACT;
      issue_rank_r <= '0;
      issue_bank_r <= '0;
      req_accept_r <= 1'b0;
    end else begin
      issue_valid_r <= iss;
      issue_kind_r <= iss_kind;
      issue_rank_r <= iss_rank;
      issue_bank_r <= go_ref ? '0 : req_bank;
      req_accept_r <= go_host;
    end
  end

  // ----------------------------------------
  // Per-bank spacing
  // ----------------------------------------
  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic [7:0] age;
    logic wrc_r;
    wire logic hit = iss && (iss_bi == (RW + BW)'(b));
    gap_age #(.W(8)) u_age (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(hit && (iss_kind == CMD_ACT)),
      .age_r(age)
    );
    // Write with page close arms the longer activate-to-activate wait
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        wrc_r <= 1'b0;
      end else if (hit && (iss_kind == CMD_WR) && req_close) begin
        wrc_r <= 1'b1;
      end else if (hit && (iss_kind == CMD_ACT)) begin
        wrc_r <= 1'b0;
      end
    end
    assign bank_ok[b] = (age >= g_same) && !(wrc_r && (age < g_wrc));
  end

  // ----------------------------------------
  // Per-rank spacing and refresh debt
  // ----------------------------------------
  for (genvar r = 0; r < RK; r++) begin : g_rank
    logic [7:0] act_age;
    logic [7:0] rd_age;
    logic [7:0] wr_age;
    logic [7:0] ref_age;
    logic [3:0] pend_r;
    wire logic here = iss && (iss_rank == RW'(r));
    wire logic same_rank = (req_gr == RW'(r));
    wire logic same_mod = (req_module == MW'(r / RANKS));
    wire logic ref_here = here && (iss_kind == CMD_REF);
    gap_age #(.W(8)) u_act (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(here && ((iss_kind == CMD_ACT) || (iss_kind == CMD_REF))),
      .age_r(act_age)
    );
    gap_age #(.W(8)) u_rd (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(here && (iss_kind == CMD_RD)),
      .age_r(rd_age)
    );
    gap_age #(.W(8)) u_wr (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(here && (iss_kind == CMD_WR)),
      .age_r(wr_age)
    );
    gap_age #(.W(8)) u_ref (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(ref_here),
      .age_r(ref_age)
    );
    assign rd_blk[r] = same_rank ? (wr_age < g_wr_rd_sr) :
                       (same_mod && ((wr_age < g_wr_rd_xr) || (rd_age < g_rd_rd_xr)));
    assign wr_blk[r] = same_mod && ((rd_age < g_rd_wr) || (wr_age < g_wr_wr));
    // Applied to any bank of the rank, a conservative reading
    assign act_blk[r] = same_rank && ((act_age < g_cross) || (ref_age < g_ref));
    assign ref_ok[r] = (&bank_ok[r*BANKS +: BANKS]) && (act_age >= g_cross) &&
                       (ref_age >= g_ref) && (pend_r != 4'h0);
    // Debt may grow to nine intervals, keeping the nine-interval average
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        pend_r <= 4'h0;
      end else if (ref_tick && !ref_here && (pend_r != `REF_MAX_PEND)) begin
        pend_r <= pend_r + 4'h1;
      end else if (ref_here && !ref_tick) begin
        pend_r <= pend_r - 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Refresh interval timer
  // ----------------------------------------
  logic [10:0] ref_sixteenths;
  logic [14:0] ref_cnt_r;

  always_comb begin
    case (dram_timing_a_r[`F_REF_CODE])
      4'h1: ref_sixteenths = `RI_1;
      4'h2: ref_sixteenths = `RI_2;
      4'h3: ref_sixteenths = `RI_3;
      4'h4: ref_sixteenths = `RI_4;
      4'h5: ref_sixteenths = `RI_5;
      4'h6: ref_sixteenths = `RI_6;
      4'h7: ref_sixteenths = `RI_7;
      4'h8: ref_sixteenths = `RI_8;
      4'h9: ref_sixteenths = `RI_9;
      4'hA: ref_sixteenths = `RI_A;
      4'hB: ref_sixteenths = `RI_B;
      4'hC: ref_sixteenths = `RI_C;
      4'hD: ref_sixteenths = `RI_D;
      4'hE: ref_sixteenths = `RI_E;
      default: ref_sixteenths = 11'h0;
    endcase
  end

  // Reserved code F is treated as disabled
  wire logic ref_on = (ref_sixteenths != 11'h0);
  wire logic [14:0] ref_last = {ref_sixteenths, 4'h0} - 15'h1;
  assign ref_tick = ref_on && (ref_cnt_r >= ref_last);

  always_ff @(posedge ref_clk) begin
    if (reset || !ref_on || ref_tick) begin
      ref_cnt_r <= 15'h0;
    end else begin
      ref_cnt_r <= ref_cnt_r + 15'h1;
    end
  end

  // ----------------------------------------
  // Early defer reply
  // ----------------------------------------
  logic [RET_LAT-1:0] rd_pipe_r;
  wire logic rd_launch = iss && (iss_kind == CMD_RD);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_pipe_r <= '0;
      early_defer_r <= 1'b0;
      data_arrive_r <= 1'b0;
    end else begin
      rd_pipe_r <= {rd_launch, rd_pipe_r[RET_LAT-1:1]};
      early_defer_r <= rd_pipe_r[defer_reply_launch_delay_r];
      data_arrive_r <= rd_pipe_r[0];
    end
  end

  // ----------------------------------------
  // Error period counter
  // ----------------------------------------
  logic [PW-1:0] pre_cnt_r;
  wire logic pre_tick = (pre_cnt_r == PW'(ERR_PRESCALE - 1));
  wire logic [31:0] period_inc = err_period_cnt_r + 32'h1;
  wire logic period_hit = pre_tick && (error_period_threshold_r != 32'h0) &&
                          (period_inc >= error_period_threshold_r);

  always_ff @(posedge ref_clk) begin
    if (reset || pre_tick) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_r + PW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      err_period_cnt_r <= 32'h0;
      err_decrement_r <= 1'b0;
    end else begin
      if (pre_tick) begin
        err_period_cnt_r <= period_hit ? 32'h0 : period_inc;
      end
      err_decrement_r <= period_hit;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  cal_mask_a: assert property (
    (!idle_ignore_train_enable_r && electrical_idle[0]) |=> !cal_detect_en_r[0])
    else $error("idle lane enabled for calibration detect");
  train_en_a: assert property (
    (cal_active && idle_ignore_train_enable_r) |=> rx_train_en_r)
    else $error("training not enabled in calibration");
  edge_off_a: assert property (
    (electrical_idle[0] && !edge_off_disable_r) |=> edge_off_r[0])
    else $error("idle lane missing edge-off");
  edge_keep_a: assert property (
    (edge_off_disable_r && !soft_core_reset && !wr_lane_defer) |=> !edge_off_r[0])
    else $error("edge-off driven while disabled");
  defer_lead_a: assert property (
    (early_defer_r && defer_reply_launch_delay_r == 4'hD) |-> ##13 data_arrive_r)
    else $error("defer reply lead wrong");
  defer_once_a: assert property (
    (defer_locked_r && wr_lane_defer) |=> $stable(defer_reply_launch_delay_r))
    else $error("locked delay changed");
  posted_flag_a: assert property (
    (write_depth_in != 6'h0) |=> writes_posted_r)
    else $error("posted flag low with queued writes");
  bank_gap_a: assert property (
    (issue_valid_r && issue_kind_r == CMD_ACT && issue_rank_r == '0 && issue_bank_r == '0 &&
     g_same == 8'h6 && !wr_timing_a) |=>
    !(issue_valid_r && issue_kind_r == CMD_ACT && issue_rank_r == '0 && issue_bank_r == '0)[*5])
    else $error("same-bank activate too soon");
  host_gate_a: assert property (
    req_accept_r |-> issue_valid_r && !$past(issue_valid_r))
    else $error("accept without issue");
  period_clear_a: assert property (
    err_decrement_r |-> (err_period_cnt_r == 32'h0))
    else $error("period counter not cleared at threshold");
  zero_period_limit_a: assert property (
    (error_period_threshold_r == 32'h0) |=> !err_decrement_r)
    else $error("decrement with zero threshold");

  cover property (issue_valid_r && issue_kind_r == CMD_REF);
  cover property (req_accept_r && issue_kind_r == CMD_WR ##[1:20] req_accept_r && issue_kind_r == CMD_RD);
  cover property (early_defer_r ##[1:15] data_arrive_r);
  cover property (err_decrement_r);
endmodule
`default_nettype wire

/* bench/mem_channel_model.sv */
// Channel side: per-lane idle sense, cycles since last issued command.
// Assumes the block's clock and synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module mem_channel_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [13:0] idle_set,
  input wire logic issue_valid_r,
  output logic [13:0] electrical_idle,
  output logic [15:0] since_issue
);
  always_ff @(posedge ref_clk) begin
    electrical_idle <= idle_set;
  end
  // Saturates so a quiet channel never wraps to a small gap
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      since_issue <= 16'h0000;
    end else if (issue_valid_r) begin
      since_issue <= 16'h0001;
    end else if (since_issue != 16'hFFFF) begin
      since_issue <= since_issue + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
// Bench: registers, lanes, status, command spacing, defer timing.
// Assumes mem_channel_model on the channel side.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import fbd_timing_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic soft_core_reset = 1'b0, cal_active = 1'b0, write_pending_in = 1'b0;
  logic req_valid = 1'b0, req_close = 1'b0, req_module = 1'b0, req_rank = 1'b0;
  logic train, acc, iv, early, arrive, dec;
  logic [1:0] irank, ibank;
  logic [1:0] req_bank = 2'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_r;
  logic [13:0] idle_set = 14'h0, electrical_idle, cal_detect_en_r, edge_off_r;
  logic [6:0] inorder_depth_in = 7'h00, deferred_depth_in = 7'h00;
  logic [5:0] write_depth_in = 6'h00;
  logic [15:0] since_issue;
  cmd_kind_t req_kind = CMD_ACT;
  cmd_kind_t ikind;
  int fails = 0, cmp_count = 0;
  fbd_memory_timing_control #(.ERR_PRESCALE(4)) dut_u (.ref_clk, .reset, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata_r, .electrical_idle, .soft_core_reset, .cal_active,
    .cal_detect_en_r, .edge_off_r, .rx_train_en_r(train), .inorder_depth_in, .deferred_depth_in,
    .write_depth_in, .write_pending_in, .req_valid, .req_kind, .req_close, .req_module, .req_rank,
    .req_bank, .req_accept_r(acc), .issue_valid_r(iv), .issue_kind_r(ikind), .issue_rank_r(irank),
    .issue_bank_r(ibank), .early_defer_r(early), .data_arrive_r(arrive), .err_decrement_r(dec));
  mem_channel_model ch_u (.ref_clk, .reset, .idle_set, .issue_valid_r(iv), .electrical_idle,
    .since_issue);
  initial forever #50 ref_clk = ~ref_clk;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 chk("rdata", exp, reg_rdata_r);
  endtask
  // Returns cycles between this issue and the previous one
  task automatic cmd(input cmd_kind_t k, input logic [1:0] b, output int gap);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_bank <= b;
    for (int i = 0; i < 60 && acc !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (acc !== 1'b1) begin
      fails++;
      wrap_up();
    end
    gap = since_issue;
    chk("issue_kind", k, ikind);
    chk("issue_rank", 0, irank);
    chk("issue_bank", b, ibank);
    @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask
  task automatic t_regs;
    rd(8'h48, 32'h0);
    rd(8'h5C, 32'h6);
    rd(8'h70, 32'h0);
    wr(8'h5C, 32'hD);
    wr(8'h5C, 32'h3);
    rd(8'h5C, 32'hD);
  endtask
  task automatic t_lanes;
    for (int m = 0; m < 8; m++) begin
      @(posedge ref_clk);
      cal_active <= m[2];
      soft_core_reset <= (m == 6);
      idle_set <= 14'h2C35 ^ 14'(m * 9);
      wr(8'h5C, {26'h0, m[1:0], 4'h3});
      repeat (3) @(posedge ref_clk);
      #1 chk("edge_off", {14{m == 6}} | (idle_set & ~{14{m[0]}}), edge_off_r);
      chk("detect", 14'({14{m[1]}} | ~idle_set), cal_detect_en_r);
      chk("train", m[2] & m[1], train);
      rd(8'h5C, {26'h0, m[1:0], 4'hD});
    end
  endtask
  task automatic t_status;
    @(posedge ref_clk);
    inorder_depth_in <= 7'h55;
    deferred_depth_in <= 7'h2A;
    write_depth_in <= 6'h21;
    write_pending_in <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(8'h50, 32'h00AA_A843);
    @(posedge ref_clk);
    inorder_depth_in <= 7'h00;
    deferred_depth_in <= 7'h00;
    write_depth_in <= 6'h00;
    write_pending_in <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(8'h50, 32'h0);
  endtask
  task automatic t_space;
    int n;
    wr(8'h48, 32'h0006_0000);
    wr(8'h4C, 32'h0000_5000);
    cmd(CMD_ACT, 2'h0, n);
    cmd(CMD_ACT, 2'h0, n);
    chk("act_gap", 1, n >= 6 && n <= 7);
    cmd(CMD_RD, 2'h1, n);
    cmd(CMD_WR, 2'h1, n);
    chk("rd_wr_gap", 1, n >= 5 && n <= 6);
  endtask
  task automatic t_defer;
    int n, hits;
    hits = 0;
    // Let pulses of earlier reads drain first
    repeat (30) @(posedge ref_clk);
    cmd(CMD_RD, 2'h2, n);
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      if (early === 1'b1) begin
        hits++;
        chk("early_defer", 32'd11, since_issue);
      end
      if (arrive === 1'b1) begin
        hits++;
        chk("arrive", 32'd24, since_issue);
      end
    end
    chk("pulses", 32'd2, hits);
  endtask
  // Edges until the next refresh to rank 0, 1100 when none comes
  task automatic wait_ref(output int n);
    for (n = 1; n < 1100; n++) begin
      @(posedge ref_clk);
      #1;
      if (iv === 1'b1 && ikind == CMD_REF && irank == 2'h0) break;
    end
  endtask
  task automatic t_refresh;
    int n;
    wr(8'h48, 32'h1006_0201);
    rd(8'h48, 32'h1006_0201);
    wait_ref(n);
    chk("ref_seen", 1, n < 1100);
    wait_ref(n);
    chk("ref_gap", 32'd1040, n);
  endtask
  // Prescale 4 and threshold 2 give one decrement every 8 cycles
  task automatic t_err;
    int hits;
    wr(8'h60, 32'h2);
    rd(8'h60, 32'h2);
    repeat (16) @(posedge ref_clk);
    hits = 0;
    repeat (80) begin
      @(posedge ref_clk);
      #1 hits += (dec === 1'b1);
    end
    chk("decrements", 32'd10, hits);
    wr(8'h60, 32'h0);
    repeat (4) @(posedge ref_clk);
    hits = 0;
    repeat (40) begin
      @(posedge ref_clk);
      #1 hits += (dec === 1'b1);
    end
    chk("no_decrement", 32'd0, hits);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_lanes();
    t_status();
    t_space();
    t_defer();
    t_refresh();
    t_err();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
